// ==== inc/ctrs_defines.svh ====
`ifndef CTRS_DEFINES_SVH
`define CTRS_DEFINES_SVH
// object indexes, 16 bits
`define CTRS_IDX_DELAY_FWD 16'h2361
`define CTRS_IDX_DELAY_REV 16'h2362
`define CTRS_IDX_MASTER_SPEED 16'h2363
`define CTRS_IDX_CAM_CONFIG 16'h2360
`define CTRS_IDX_RESERVED 16'h250a
`define CTRS_IDX_POINTER 16'h250b
`define CTRS_IDX_DATA 16'h250c
// limits and sizes
`define CTRS_RAM_WORDS 2048
`define CTRS_MAX_TABLES 16
`define CTRS_DELAY_MAX 16'h7fff
`define CTRS_FIFO_DEPTH 16
// camming configuration fields
`define CTRS_CFG_TABLE_LSB 0
`define CTRS_CFG_RAM_SEL_BIT 7
`define CTRS_CFG_GEN_SEL_BIT 6
// compressed marker bits of first data word
`define CTRS_CMP_SET_BIT 14
`define CTRS_CMP_CLR_BIT 15
// reset values
`define CTRS_RST_WORD 16'h0000
`endif

// ==== inc/ctrs_pkg.sv ====
package ctrs_pkg;
    // object dictionary access from the network side
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] index;
        logic [15:0] wdata;
    } ctrs_req_t;
    // one cam step handed to the motion logic
    typedef struct packed {
        logic [15:0] master_inc;
        logic [15:0] slave_inc;
        logic last;
    } ctrs_step_t;
    typedef enum logic [2:0] {
        CTRS_IDLE,
        CTRS_META_START,
        CTRS_META_LEN,
        CTRS_FIRST,
        CTRS_MASTER,
        CTRS_SLAVE
    } ctrs_state_t;
endpackage : ctrs_pkg

// ==== design/ctrs_fifo.sv ====
`timescale 1ns/1ps
module ctrs_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // fill side
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    // drain side
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic full;
    logic empty;
    assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    assign empty = (wp == rp);
    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data = mem[rp[AW-1:0]];
    always_ff @(posedge i_ref_clk) begin
        if (i_valid && !full) begin
            mem[wp[AW-1:0]] <= i_data;
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            wp <= '0;
        end else if (i_valid && !full) begin
            wp <= wp + 1'b1;
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            rp <= '0;
        end else if (i_ready && !empty) begin
            rp <= rp + 1'b1;
        end
    end
endmodule : ctrs_fifo

// ==== design/ctrs_cam_store.sv ====
`timescale 1ns/1ps
// Summary of operation
// - forward trigger waits forward delay counts
// - reverse trigger waits reverse delay counts
// - signed virtual master speed drives generator
// - reserved size setting, zero to 2048
// - write pointer word offset, zero to 2048
// - first write at pointer, then increments
// - 2048 sixteen-bit words, sixteen tables
// - tables use ram only when trace idle
// - buffer starts with start/length pairs
// - standard format: master then slave words
// - metadata pair at twice table number
// - compressed: bit14 set, bit15 clear marker
// - data port read also advances pointer
// - config bit selects ram or flash
// - table number from config low nibble
`include "ctrs_defines.svh"
module ctrs_cam_store
    import ctrs_pkg::*;
#(
    parameter int RAM_WORDS = `CTRS_RAM_WORDS,
    parameter int FIFO_DEPTH = `CTRS_FIFO_DEPTH
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // object access
    input wire ctrs_req_t i_req,
    output logic [15:0] o_rdata,
    output logic o_rvalid,
    // trace capture ownership
    input wire logic i_trace_busy,
    // camming control
    input wire logic i_cam_start,
    input wire logic i_trigger,
    input wire logic i_master_fwd,
    input wire logic i_master_tick,
    // outputs to motion logic
    output logic o_use_flash,
    output logic o_generator_sel,
    output logic [15:0] o_master_speed,
    output logic o_profile_go,
    output logic o_running,
    output ctrs_step_t o_step,
    output logic o_step_valid,
    input wire logic i_step_ready
);
    localparam int AW = $clog2(RAM_WORDS);
    // refused at elaboration, the address logic assumes this size
    if (RAM_WORDS != `CTRS_RAM_WORDS) begin : g_bad_ram
        $error("ram must hold 2048 words");
    end
    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_fifo
        $error("fifo depth must be a power of two");
    end
    function automatic logic hit(input ctrs_req_t r, input logic [15:0] idx);
        hit = r.index == idx;
    endfunction : hit
    // metadata pair sits at twice the table id
    function automatic logic [15:0] meta_addr(input logic [15:0] cfg);
        meta_addr = 16'({cfg[`CTRS_CFG_TABLE_LSB +: 4], 1'b0});
    endfunction : meta_addr

    // pins from other logic on same clock; trigger is a pin
    // two flops against metastability, third only for the edge
    logic trig_s1;
    logic trig_s2;
    logic trig_q;
    always_ff @(posedge i_ref_clk) begin
        trig_s1 <= i_trigger;
        trig_s2 <= trig_s1;
        trig_q <= trig_s2;
    end

    logic [15:0] delay_fwd;
    logic [15:0] delay_rev;
    logic [15:0] master_speed;
    logic [15:0] reserved_words;
    logic [15:0] wr_pointer;
    logic [15:0] cam_config;
    // table ram, 2048 words of 16 bits
    logic [15:0] ram [RAM_WORDS];

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            delay_fwd <= `CTRS_RST_WORD;
        end else if (i_req.wr && hit(i_req, `CTRS_IDX_DELAY_FWD)) begin
            delay_fwd <= i_req.wdata & `CTRS_DELAY_MAX;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            delay_rev <= `CTRS_RST_WORD;
        end else if (i_req.wr && hit(i_req, `CTRS_IDX_DELAY_REV)) begin
            delay_rev <= i_req.wdata & `CTRS_DELAY_MAX;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            master_speed <= `CTRS_RST_WORD;
        end else if (i_req.wr && hit(i_req, `CTRS_IDX_MASTER_SPEED)) begin
            master_speed <= i_req.wdata;
        end
    end

    // camming configuration word
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            cam_config <= `CTRS_RST_WORD;
        end else if (i_req.wr && hit(i_req, `CTRS_IDX_CAM_CONFIG)) begin
            cam_config <= i_req.wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            reserved_words <= `CTRS_RST_WORD;
        end else if (i_req.wr && hit(i_req, `CTRS_IDX_RESERVED)) begin
            if (i_req.wdata > 16'(RAM_WORDS)) begin
                reserved_words <= 16'(RAM_WORDS);
            end else begin
                reserved_words <= i_req.wdata;
            end
        end
    end

    logic data_wr;
    logic data_rd;
    logic in_region;
    assign data_wr = i_req.wr && hit(i_req, `CTRS_IDX_DATA);
    assign data_rd = i_req.rd && hit(i_req, `CTRS_IDX_DATA);
    // pointer parks at the size; stores there are dropped
    assign in_region = wr_pointer < reserved_words;

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            wr_pointer <= `CTRS_RST_WORD;
        end else if (i_req.wr && hit(i_req, `CTRS_IDX_POINTER)) begin
            wr_pointer <= (i_req.wdata > 16'(RAM_WORDS)) ? 16'(RAM_WORDS) : i_req.wdata;
        end else if ((data_wr || data_rd) && in_region) begin
            // advance on access; stops at size
            wr_pointer <= wr_pointer + 16'h0001;
        end
    end

    // cam fetch blocked while trace owns ram
    logic fetch_en;
    logic [AW-1:0] fetch_addr;
    logic [15:0] fetch_q;
    always_ff @(posedge i_ref_clk) begin
        if (data_wr && in_region && !i_trace_busy) begin
            ram[wr_pointer[AW-1:0]] <= i_req.wdata;
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (fetch_en) begin
            fetch_q <= ram[fetch_addr];
        end
    end

    // register reads, one cycle after request
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_rdata <= `CTRS_RST_WORD;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_req.rd;
            if (i_req.rd) begin
                unique case (i_req.index)
                    `CTRS_IDX_DELAY_FWD: o_rdata <= delay_fwd;
                    `CTRS_IDX_DELAY_REV: o_rdata <= delay_rev;
                    `CTRS_IDX_MASTER_SPEED: o_rdata <= master_speed;
                    `CTRS_IDX_CAM_CONFIG: o_rdata <= cam_config;
                    `CTRS_IDX_RESERVED: o_rdata <= reserved_words;
                    `CTRS_IDX_POINTER: o_rdata <= wr_pointer;
                    `CTRS_IDX_DATA: o_rdata <= in_region ? ram[wr_pointer[AW-1:0]] : 16'h0000;
                    default: o_rdata <= 16'h0000;
                endcase
            end
        end
    end

    assign o_use_flash = !cam_config[`CTRS_CFG_RAM_SEL_BIT];
    assign o_generator_sel = cam_config[`CTRS_CFG_GEN_SEL_BIT];
    assign o_master_speed = master_speed;

    // trigger delay in master counts
    logic [15:0] delay_cnt;
    logic delay_busy;
    logic trig_rise;
    assign trig_rise = trig_s2 && !trig_q;
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            delay_cnt <= 16'h0000;
            delay_busy <= 1'b0;
            o_profile_go <= 1'b0;
        end else begin
            o_profile_go <= 1'b0;
            if (trig_rise && !delay_busy) begin
                delay_cnt <= i_master_fwd ? delay_fwd : delay_rev;
                delay_busy <= 1'b1;
            end else if (delay_busy) begin
                // zero delay still fires one cycle after load
                if (delay_cnt == 16'h0000) begin
                    delay_busy <= 1'b0;
                    o_profile_go <= 1'b1;
                end else if (i_master_tick) begin
                    delay_cnt <= delay_cnt - 16'h0001;
                end
            end
        end
    end

    // table walker
    ctrs_state_t state;
    logic [15:0] tbl_addr;
    logic [15:0] tbl_left;
    logic compressed;
    logic [15:0] const_master;
    logic [15:0] held_master;
    logic pend;
    logic fifo_ready;
    logic push;
    ctrs_step_t push_step;
    logic start_walk;

    // tables run only when ram is selected
    assign start_walk = i_cam_start && cam_config[`CTRS_CFG_RAM_SEL_BIT];
    // one fetch in flight, so a full fifo never overflows
    assign fetch_en = !i_trace_busy && !pend && fifo_ready;
    always_comb begin
        fetch_addr = tbl_addr[AW-1:0];
        if (state == CTRS_IDLE) begin
            fetch_addr = AW'(meta_addr(cam_config));
        end
    end

    // pend marks fetch_q as fresh; the idle start fetch counts too
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            pend <= 1'b0;
        end else begin
            pend <= fetch_en && (state != CTRS_IDLE || start_walk);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            state <= CTRS_IDLE;
            tbl_addr <= 16'h0000;
            tbl_left <= 16'h0000;
            compressed <= 1'b0;
            const_master <= 16'h0000;
            held_master <= 16'h0000;
            push <= 1'b0;
            push_step <= '0;
        end else begin
            push <= 1'b0;
            unique case (state)
                CTRS_IDLE: begin
                    if (start_walk && fetch_en) begin
                        // length word is next after the start word
                        tbl_addr <= meta_addr(cam_config) + 16'h0001;
                        state <= CTRS_META_START;
                    end
                end
                CTRS_META_START: if (pend) begin
                    // first word start offset, parked until length read
                    tbl_left <= fetch_q;
                    state <= CTRS_META_LEN;
                end
                CTRS_META_LEN: if (pend) begin
                    tbl_left <= fetch_q;
                    tbl_addr <= tbl_left;
                    state <= (fetch_q == 16'h0000) ? CTRS_IDLE : CTRS_FIRST;
                end
                CTRS_FIRST: if (pend) begin
                    compressed <= fetch_q[`CTRS_CMP_SET_BIT] && !fetch_q[`CTRS_CMP_CLR_BIT];
                    const_master <= fetch_q;
                    held_master <= fetch_q;
                    tbl_addr <= tbl_addr + 16'h0001;
                    tbl_left <= tbl_left - 16'h0001;
                    state <= (tbl_left == 16'h0001) ? CTRS_IDLE : CTRS_SLAVE;
                end
                CTRS_MASTER: if (pend) begin
                    held_master <= fetch_q;
                    tbl_addr <= tbl_addr + 16'h0001;
                    tbl_left <= tbl_left - 16'h0001;
                    state <= (tbl_left == 16'h0001) ? CTRS_IDLE : CTRS_SLAVE;
                end
                CTRS_SLAVE: if (pend) begin
                    push <= 1'b1;
                    push_step.master_inc <= compressed ?
                        {2'b00, const_master[13:0]} : held_master;
                    push_step.slave_inc <= fetch_q;
                    push_step.last <= (tbl_left == 16'h0001);
                    tbl_addr <= tbl_addr + 16'h0001;
                    tbl_left <= tbl_left - 16'h0001;
                    if (tbl_left == 16'h0001) begin
                        state <= CTRS_IDLE;
                    end else begin
                        state <= compressed ? CTRS_SLAVE : CTRS_MASTER;
                    end
                end
                default: state <= CTRS_IDLE;
            endcase
        end
    end

    assign o_running = (state != CTRS_IDLE);

    // no fetch while a push is still landing in the fifo
    logic fifo_in_ready;
    assign fifo_ready = fifo_in_ready && !push && !pend;

    ctrs_fifo #(
        .WIDTH($bits(ctrs_step_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_valid(push),
        .o_ready(fifo_in_ready),
        .i_data(push_step),
        .o_valid(o_step_valid),
        .i_ready(i_step_ready),
        .o_data(o_step)
    );
endmodule : ctrs_cam_store

// ==== test/ctrs_cam_store_checker.sv ====
`timescale 1ns/1ps
`include "ctrs_defines.svh"
module ctrs_cam_store_checker
    import ctrs_pkg::*;
#(
    parameter int RAM_WORDS = `CTRS_RAM_WORDS,
    parameter int FIFO_DEPTH = `CTRS_FIFO_DEPTH
) (
    // clock, reset, object bus
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire ctrs_req_t i_req,
    input wire logic [15:0] o_rdata,
    input wire logic o_rvalid,
    // camming side
    input wire logic i_trace_busy,
    input wire logic i_cam_start,
    input wire logic i_trigger,
    input wire logic i_master_fwd,
    input wire logic i_master_tick,
    input wire logic o_use_flash,
    input wire logic o_generator_sel,
    input wire logic [15:0] o_master_speed,
    input wire logic o_profile_go,
    input wire logic o_running,
    input wire ctrs_step_t o_step,
    input wire logic o_step_valid,
    input wire logic i_step_ready
);
    logic [15:0] fwd, rev, spd, resv, cfg;
    // shadow copies of written objects, reserved size clamped
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            fwd <= 16'h0000;
            rev <= 16'h0000;
            spd <= 16'h0000;
            resv <= 16'h0000;
            cfg <= 16'h0000;
        end else if (i_req.wr) begin
            case (i_req.index)
                `CTRS_IDX_DELAY_FWD: fwd <= i_req.wdata & `CTRS_DELAY_MAX;
                `CTRS_IDX_DELAY_REV: rev <= i_req.wdata & `CTRS_DELAY_MAX;
                `CTRS_IDX_MASTER_SPEED: spd <= i_req.wdata;
                `CTRS_IDX_CAM_CONFIG: cfg <= i_req.wdata;
                `CTRS_IDX_RESERVED: resv <= (i_req.wdata > 16'(RAM_WORDS)) ?
                    16'(RAM_WORDS) : i_req.wdata;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    chk_rvalid_after_rd: assert property (i_req.rd |=> o_rvalid)
        else $error("read not answered next cycle");
    chk_rvalid_has_cause: assert property (o_rvalid |-> $past(i_req.rd))
        else $error("read valid without read");
    chk_fwd_readback: assert property (
        i_req.rd && i_req.index == `CTRS_IDX_DELAY_FWD |=> o_rdata == $past(fwd))
        else $error("forward delay readback wrong");
    chk_rev_readback: assert property (
        i_req.rd && i_req.index == `CTRS_IDX_DELAY_REV |=> o_rdata == $past(rev))
        else $error("reverse delay readback wrong");
    chk_resv_readback: assert property (
        i_req.rd && i_req.index == `CTRS_IDX_RESERVED |=> o_rdata == $past(resv))
        else $error("reserved size readback wrong");
    chk_speed_output: assert property (
        o_master_speed == spd && o_generator_sel == cfg[`CTRS_CFG_GEN_SEL_BIT])
        else $error("speed or generator select wrong");
    chk_flash_select: assert property (o_use_flash == !cfg[`CTRS_CFG_RAM_SEL_BIT])
        else $error("flash select wrong");
    chk_go_pulse: assert property (o_profile_go |=> !o_profile_go)
        else $error("profile go longer than one cycle");
    chk_step_holds: assert property (
        o_step_valid && !i_step_ready |=> o_step_valid && $stable(o_step))
        else $error("step changed while stalled");
    cov_go: cover property (o_profile_go);
    cov_pop: cover property (o_step_valid && i_step_ready && o_step.last);
    cov_stall: cover property (o_step_valid && !i_step_ready && o_running);
endmodule : ctrs_cam_store_checker
bind ctrs_cam_store ctrs_cam_store_checker #(.RAM_WORDS(RAM_WORDS), .FIFO_DEPTH(FIFO_DEPTH))
    ctrs_cam_store_checker_inst (.i_ref_clk, .i_nrst, .i_req, .o_rdata, .o_rvalid,
    .i_trace_busy, .i_cam_start, .i_trigger, .i_master_fwd, .i_master_tick, .o_use_flash,
    .o_generator_sel, .o_master_speed, .o_profile_go, .o_running, .o_step, .o_step_valid,
    .i_step_ready);

// ==== test/ctrs_net_ctrl.sv ====
`timescale 1ns/1ps
module ctrs_net_ctrl
    import ctrs_pkg::*;
(
    // clock
    input wire logic i_ref_clk,
    // object bus
    output ctrs_req_t o_req,
    input wire logic [15:0] i_rdata,
    input wire logic i_rvalid
);
    initial o_req = '0;
    // strobe held over one edge, released after it
    task automatic wr_obj(input logic [15:0] idx, input logic [15:0] d);
        @(posedge i_ref_clk);
        #1 o_req = '{wr: 1'b1, rd: 1'b0, index: idx, wdata: d};
        @(posedge i_ref_clk);
        #1 o_req = '0;
    endtask : wr_obj
    task automatic rd_obj(input logic [15:0] idx, output logic [15:0] d);
        @(posedge i_ref_clk);
        #1 o_req = '{wr: 1'b0, rd: 1'b1, index: idx, wdata: 16'h0000};
        @(posedge i_ref_clk);
        #1 o_req = '0;
        d = i_rvalid ? i_rdata : 16'hxxxx;
    endtask : rd_obj
endmodule : ctrs_net_ctrl

// ==== test/tb_ctrs_cam_store.sv ====
`timescale 1ns/1ps
`include "ctrs_defines.svh"
module tb_ctrs_cam_store;
    import ctrs_pkg::*;
    logic i_ref_clk, i_nrst, i_trace_busy, i_cam_start, i_trigger, i_master_fwd;
    logic i_master_tick, i_step_ready, o_rvalid, o_use_flash, o_generator_sel;
    logic o_profile_go, o_running, o_step_valid;
    int go_count = 0;
    logic [15:0] o_rdata, o_master_speed, rd;
    ctrs_req_t i_req;
    ctrs_step_t o_step;
    ctrs_step_t got[$];
    int failures = 0;
    int num_checks = 0;
    ctrs_cam_store ctrs_cam_store_inst (.i_ref_clk, .i_nrst, .i_req, .o_rdata, .o_rvalid,
        .i_trace_busy, .i_cam_start, .i_trigger, .i_master_fwd, .i_master_tick, .o_use_flash,
        .o_generator_sel, .o_master_speed, .o_profile_go, .o_running, .o_step, .o_step_valid,
        .i_step_ready);
    ctrs_net_ctrl ctrs_net_ctrl_inst (.i_ref_clk, .o_req(i_req), .i_rdata(o_rdata),
        .i_rvalid(o_rvalid));
    initial begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        if (o_profile_go === 1'b1) go_count <= go_count + 1;
    end
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        ctrs_net_ctrl_inst.wr_obj(idx, d);
    endtask : wr
    task automatic rdchk(input logic [15:0] idx, input logic [15:0] e);
        ctrs_net_ctrl_inst.rd_obj(idx, rd);
        check(rd, e);
    endtask : rdchk
    task automatic put(input logic [15:0] at, input logic [15:0] w[$]);
        wr(`CTRS_IDX_POINTER, at);
        foreach (w[i]) wr(`CTRS_IDX_DATA, w[i]);
    endtask : put
    task automatic t_regs;
        wr(`CTRS_IDX_DELAY_FWD, 16'hffff);
        rdchk(`CTRS_IDX_DELAY_FWD, 16'h7fff);
        wr(`CTRS_IDX_DELAY_REV, 16'h8005);
        rdchk(`CTRS_IDX_DELAY_REV, 16'h0005);
        wr(`CTRS_IDX_MASTER_SPEED, 16'hfff6);
        rdchk(`CTRS_IDX_MASTER_SPEED, 16'hfff6);
        check(o_master_speed, 16'hfff6);
        wr(`CTRS_IDX_RESERVED, 16'h0801);
        rdchk(`CTRS_IDX_RESERVED, 16'h0800);
        wr(`CTRS_IDX_POINTER, 16'hffff);
        rdchk(`CTRS_IDX_POINTER, 16'h0800);
        rdchk(16'h2364, 16'h0000);
    endtask : t_regs
    task automatic t_port;
        wr(`CTRS_IDX_RESERVED, 16'h0008);
        put(16'h0002, {16'ha000, 16'ha001, 16'ha002});
        rdchk(`CTRS_IDX_POINTER, 16'h0005);
        wr(`CTRS_IDX_POINTER, 16'h0002);
        for (int i = 0; i < 3; i++) rdchk(`CTRS_IDX_DATA, 16'ha000 + 16'(i));
        rdchk(`CTRS_IDX_POINTER, 16'h0005);
        put(16'h0007, {16'hb007, 16'hb008});
        rdchk(`CTRS_IDX_POINTER, 16'h0008);
        i_trace_busy = 1'b1;
        put(16'h0002, {16'h5555});
        i_trace_busy = 1'b0;
        wr(`CTRS_IDX_POINTER, 16'h0002);
        rdchk(`CTRS_IDX_DATA, 16'ha000);
    endtask : t_port
    // stall the drain side, then collect n steps
    task automatic run_table(input logic [15:0] cfg, input int n, input int stall);
        wr(`CTRS_IDX_CAM_CONFIG, cfg);
        check({15'h0, o_use_flash}, 16'h0000);
        check({15'h0, o_generator_sel}, {15'h0, cfg[`CTRS_CFG_GEN_SEL_BIT]});
        i_cam_start = 1'b1;
        @(posedge i_ref_clk);
        #1 i_cam_start = 1'b0;
        repeat (stall) @(posedge i_ref_clk);
        if (stall > 30) check({14'h0, o_running, o_step_valid}, 16'h0003);
        #1 i_step_ready = 1'b1;
        got.delete();
        for (int k = 0; k < 400 && got.size() < n; k++) begin
            @(posedge i_ref_clk);
            if (o_step_valid === 1'b1) got.push_back(o_step);
        end
        #1 i_step_ready = 1'b0;
        check(16'(got.size()), 16'(n));
    endtask : run_table
    task automatic t_std;
        wr(`CTRS_IDX_RESERVED, 16'h0800);
        put(16'h0000, {16'h003c, 16'h0002});
        put(16'h003c, {16'h1111, 16'h2222});
        put(16'h001e, {16'h0020, 16'h0004});
        put(16'h0020, {16'h0064, 16'h0032, 16'h00c8, 16'hfff0});
        run_table(16'h00cf, 2, 2);
        check(got[0].master_inc, 16'h0064);
        check(got[0].slave_inc, 16'h0032);
        check(got[1].master_inc, 16'h00c8);
        check({got[1].slave_inc[14:0], got[1].last}, 16'hffe1);
    endtask : t_std
    task automatic t_cmp;
        logic [15:0] w[$];
        w = {16'h4032};
        for (int i = 0; i < 20; i++) w.push_back(16'h0100 + 16'(i));
        put(16'h0004, {16'h0028, 16'h0015});
        put(16'h0028, w);
        run_table(16'h0082, 20, 60);
        foreach (got[i]) begin
            check(got[i].master_inc, 16'h0032);
            check(got[i].slave_inc, 16'h0100 + 16'(i));
            check({15'h0, got[i].last}, {15'h0, i == 19});
        end
    endtask : t_cmp
    // reset after the table runs clears the register objects; ram keeps its words
    task automatic t_reset;
        @(posedge i_ref_clk);
        #1 i_nrst = 1'b0;
        repeat (2) @(posedge i_ref_clk);
        #1 i_nrst = 1'b1;
        check({15'h0, o_use_flash}, 16'h0001);
        rdchk(`CTRS_IDX_DELAY_FWD, 16'h0000);
        rdchk(`CTRS_IDX_POINTER, 16'h0000);
    endtask : t_reset
    // tick every fourth cycle, count ticks until go
    task automatic t_trig(input logic fwd, input int dly);
        int n;
        int g;
        n = 0;
        g = go_count;
        @(posedge i_ref_clk);
        #1 i_master_fwd = fwd;
        i_trigger = 1'b1;
        repeat (4) @(posedge i_ref_clk);
        for (int k = 0; k < 40 && go_count == g; k++) begin
            #1 i_master_tick = 1'b1;
            n++;
            @(posedge i_ref_clk);
            #1 i_master_tick = 1'b0;
            repeat (3) @(posedge i_ref_clk);
        end
        check(16'(n), 16'(dly));
        #1 i_trigger = 1'b0;
        repeat (4) @(posedge i_ref_clk);
    endtask : t_trig
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        i_nrst = 1'b0;
        i_trace_busy = 1'b0;
        i_cam_start = 1'b0;
        i_trigger = 1'b0;
        i_master_fwd = 1'b1;
        i_master_tick = 1'b0;
        i_step_ready = 1'b0;
        repeat (10) @(posedge i_ref_clk);
        #1 i_nrst = 1'b1;
        check({15'h0, o_use_flash}, 16'h0001);
        t_regs();
        t_port();
        t_std();
        t_cmp();
        t_reset();
        wr(`CTRS_IDX_DELAY_FWD, 16'h0003);
        wr(`CTRS_IDX_DELAY_REV, 16'h0005);
        t_trig(1'b1, 3);
        t_trig(1'b0, 5);
        report_and_stop();
    end
    initial begin
        #500000;
        failures++;
        report_and_stop();
    end
endmodule : tb_ctrs_cam_store
